// ===== src/ipr_pkg.sv
// Constants, register map and state type of the interrupt priority block
package ipr_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_SRC   = 18;
    localparam int NUM_WORDS = 5;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_PRIO0  = 8'h00;
    localparam logic [7:0] OFF_PRIO1  = 8'h04;
    localparam logic [7:0] OFF_PRIO2  = 8'h08;
    localparam logic [7:0] OFF_PRIO3  = 8'h0C;
    localparam logic [7:0] OFF_PRIO4  = 8'h10;
    localparam logic [7:0] OFF_ENABLE = 8'h14;
    localparam logic [7:0] OFF_PEND   = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1C;

    // ------------------------------------------------------------
    // Status word field positions
    // ------------------------------------------------------------
    localparam int STAT_LVL_LSB   = 0;
    localparam int STAT_SRC_LSB   = 4;
    localparam int STAT_VALID_BIT = 15;

    // ------------------------------------------------------------
    // Priority word layout
    // ------------------------------------------------------------
    // Implemented bits per word
    localparam logic [NUM_WORDS-1:0][15:0] PRIO_MASK = {
        16'h7077, 16'h0777, 16'h7777, 16'h7777, 16'h7777};
    // Field msb set, lower two clear
    localparam logic [NUM_WORDS-1:0][15:0] PRIO_RST = {
        16'h4044, 16'h0444, 16'h4444, 16'h4444, 16'h4444};
    // Source order: timer1 outcmp1 incap1 ext0 timer2 outcmp2 incap2 xfer0
    // serial1_rx sync_ev sync_err timer3 xfer1 converter1 serial1_tx
    // pin_change twi1_master twi1_slave
    localparam logic [NUM_SRC-1:0][2:0] SRC_WORD = {
        3'h4, 3'h4, 3'h4, 3'h3, 3'h3, 3'h3,
        3'h2, 3'h2, 3'h2, 3'h2, 3'h1, 3'h1,
        3'h1, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0};
    localparam logic [NUM_SRC-1:0][3:0] SRC_LSB = {
        4'h0, 4'h4, 4'hC, 4'h0, 4'h4, 4'h8,
        4'h0, 4'h4, 4'h8, 4'hC, 4'h0, 4'h4,
        4'h8, 4'hC, 4'h0, 4'h4, 4'h8, 4'hC};

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NUM_WORDS-1:0][15:0] prio;
        logic [NUM_SRC-1:0]         en;
        logic                       rdy;
        logic                       err;
        logic [31:0]                rdata;
        logic                       valid;
        logic [4:0]                 src;
        logic [2:0]                 lvl;
    } ipr_state_s;

    localparam ipr_state_s IPR_RST = '{
        prio:  PRIO_RST,
        en:    '0,
        rdy:   1'b0,
        err:   1'b0,
        rdata: 32'h0,
        valid: 1'b0,
        src:   5'h00,
        lvl:   3'h0};

endpackage

// ===== src/ipr_ctrl.sv
// Interrupt priority words 0 to 4 with enable gating and APB access
`timescale 1ns/10ps
module ipr_ctrl
    import ipr_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    input  wire logic [NUM_SRC-1:0] irq_req,
    output logic                    irq_valid,
    output logic [4:0]              irq_source,
    output logic [2:0]              irq_level
);

    // ------------------------------------------------------------
    // State and helpers
    // ------------------------------------------------------------
    ipr_state_s                 st_q;
    ipr_state_s                 st_d;
    logic [NUM_SRC-1:0][2:0]    lvls;
    logic [NUM_SRC-1:0]         pend;
    logic [2:0]                 best_lvl;
    logic [4:0]                 best_src;
    logic [7:0]                 addr8;
    logic                       setup;
    logic                       done;
    logic                       hit_prio;
    logic [2:0]                 widx;
    logic [15:0]                bmask;
    logic [15:0]                wnew;

    // Upper address bits beyond the map make the access unmapped
    assign addr8 = paddr[7:0];
    assign setup = psel & ~penable;
    assign done  = psel & penable & st_q.rdy;
    assign bmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d     = st_q;
        hit_prio = (addr8[1:0] == 2'h0) && (addr8 <= OFF_PRIO4)
                   && (paddr[ADDR_W-1:5] == '0);
        widx     = addr8[4:2];
        wnew     = 16'h0000;

        // Field extraction, code maps straight to level
        for (int s = 0; s < NUM_SRC; s++) begin
            lvls[s] = st_q.prio[SRC_WORD[s]][SRC_LSB[s] +: 3];
            // Zero code or cleared enable keeps a source out
            pend[s] = irq_req[s] & st_q.en[s] & (lvls[s] != 3'h0);
        end

        // Strict compare: ties go to the lowest source number
        best_lvl = 3'h0;
        best_src = 5'h00;
        for (int s = 0; s < NUM_SRC; s++) begin
            if (pend[s] && (lvls[s] > best_lvl)) begin
                best_lvl = lvls[s];
                best_src = 5'(s);
            end
        end
        st_d.valid = (best_lvl != 3'h0);
        st_d.src   = best_src;
        st_d.lvl   = best_lvl;

        // Read data is captured in the setup cycle, so prdata is a flop
        if (setup) begin
            st_d.rdy   = 1'b1;
            st_d.err   = 1'b0;
            st_d.rdata = 32'h0;
            if (hit_prio) begin
                st_d.rdata[15:0] = st_q.prio[widx] & PRIO_MASK[widx];
            end else if (paddr[ADDR_W-1:5] != '0) begin
                st_d.err = 1'b1;
            end else begin
                unique case (addr8)
                    OFF_ENABLE: begin
                        st_d.rdata[NUM_SRC-1:0] = st_q.en;
                    end
                    OFF_PEND: begin
                        st_d.rdata[NUM_SRC-1:0] = pend;
                    end
                    OFF_STATUS: begin
                        st_d.rdata[STAT_LVL_LSB +: 3] = st_q.lvl;
                        st_d.rdata[STAT_SRC_LSB +: 5] = st_q.src;
                        st_d.rdata[STAT_VALID_BIT]    = st_q.valid;
                    end
                    default: begin
                        st_d.err = 1'b1;
                    end
                endcase
            end
        end else if (done) begin
            st_d.rdy = 1'b0;
            // Writes land at the completing edge, unimplemented bits dropped
            if (pwrite && !st_q.err) begin
                if (hit_prio) begin
                    wnew = (st_q.prio[widx] & ~bmask) | (pwdata[15:0] & bmask);
                    st_d.prio[widx] = wnew & PRIO_MASK[widx];
                end else if (addr8 == OFF_ENABLE) begin
                    for (int b = 0; b < NUM_SRC; b++) begin
                        if (pstrb[b/8]) begin
                            st_d.en[b] = pwdata[b];
                        end
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_q <= IPR_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pready     = st_q.rdy;
    assign prdata     = st_q.rdata;
    assign pslverr    = st_q.err & st_q.rdy;
    assign irq_valid  = st_q.valid;
    assign irq_source = st_q.src;
    assign irq_level  = st_q.lvl;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    reset_value_a: assert property (
        $past(!nrst) |-> (st_q.prio == PRIO_RST))
        else $error("priority words not at reset value after reset");

    unimpl_zero_a: assert property (
        ((st_q.prio[0] & ~PRIO_MASK[0]) == 16'h0000)
        && ((st_q.prio[3] & ~PRIO_MASK[3]) == 16'h0000)
        && ((st_q.prio[4] & ~PRIO_MASK[4]) == 16'h0000))
        else $error("unimplemented priority bit is set");

    disabled_quiet_a: assert property (
        irq_valid |-> ($past(lvls[best_src]) != 3'h0))
        else $error("source with zero priority was presented");

    level_direct_a: assert property (
        irq_valid |-> (irq_level == $past(lvls[best_src])))
        else $error("presented level differs from field code");

    enable_gate_a: assert property (
        irq_valid |-> $past(st_q.en[best_src] & irq_req[best_src]))
        else $error("request presented without enable");

    none_pending_a: assert property (
        (pend == '0) |=> !irq_valid)
        else $error("request presented while none pending");

    highest_wins_a: assert property (
        (pend[0] && (lvls[0] == 3'h7)) |=> (irq_valid && (irq_source == 5'h00)))
        else $error("top level source zero not presented");

    write_word0_a: assert property (
        (done && pwrite && !st_q.err && (addr8 == OFF_PRIO0) && (pstrb[1:0] == 2'h3))
        |=> (st_q.prio[0] == ($past(pwdata[15:0]) & PRIO_MASK[0])))
        else $error("write to priority word 0 not applied");

    read_word3_a: assert property (
        (setup && !pwrite && (paddr == ADDR_W'(OFF_PRIO3)))
        |=> (pready && (prdata == {16'h0000, st_q.prio[3] & PRIO_MASK[3]})))
        else $error("priority word 3 read back wrong");

    word4_map_a: assert property (
        (st_q.prio[4][11:7] == 5'h00) && (lvls[15] == st_q.prio[4][14:12]))
        else $error("priority word 4 layout broken");

    word_map_a: assert property (
        (lvls[7] == st_q.prio[1][2:0]) && (lvls[8] == st_q.prio[2][14:12]))
        else $error("priority word 1 or 2 layout broken");

    unmapped_err_a: assert property (
        (setup && (paddr == ADDR_W'(8'h20))) |=> (pready && pslverr))
        else $error("unmapped address gave no error");

    // ------------------------------------------------------------
    // Bus handshake checks
    // ------------------------------------------------------------
    ready_setup_a: assert property (
        setup |=> pready)
        else $error("no ready in the cycle after setup");

    ready_single_a: assert property (
        (pready && psel && penable) |=> !pready)
        else $error("ready held past the access cycle");

    err_data_a: assert property (
        pslverr |-> (prdata == 32'h0))
        else $error("refused access returned nonzero data");

    unaligned_err_a: assert property (
        (setup && (paddr[1:0] != 2'h0)) |=> pslverr)
        else $error("unaligned access not refused");

    high_addr_err_a: assert property (
        (setup && (paddr[ADDR_W-1:5] != '0)) |=> pslverr)
        else $error("access above the map not refused");

    refused_write_a: assert property (
        (done && pwrite && st_q.err) |=> ($stable(st_q.prio) && $stable(st_q.en)))
        else $error("refused write changed a register");

    ro_write_a: assert property (
        (setup && pwrite && ((paddr == ADDR_W'(OFF_PEND)) || (paddr == ADDR_W'(OFF_STATUS))))
        |=> (pready && !pslverr))
        else $error("write to a status word was refused");

    // ------------------------------------------------------------
    // Register access checks
    // ------------------------------------------------------------
    write_any_a: assert property (
        (done && pwrite && !st_q.err && hit_prio && (pstrb[1:0] == 2'h3))
        |=> (st_q.prio[$past(widx)] == ($past(pwdata[15:0]) & PRIO_MASK[$past(widx)])))
        else $error("priority word write not applied");

    prio_hold_a: assert property (
        !(done && pwrite) |=> $stable(st_q.prio))
        else $error("priority word changed without a write");

    enable_hold_a: assert property (
        !(done && pwrite) |=> $stable(st_q.en))
        else $error("enable word changed without a write");

    enable_write_a: assert property (
        (done && pwrite && !st_q.err && (addr8 == OFF_ENABLE) && (pstrb[2:0] == 3'h7))
        |=> (st_q.en == $past(pwdata[NUM_SRC-1:0])))
        else $error("enable word write not applied");

    enable_read_a: assert property (
        (setup && !pwrite && (paddr == ADDR_W'(OFF_ENABLE)))
        |=> ((prdata[NUM_SRC-1:0] == $past(st_q.en)) && (prdata[31:NUM_SRC] == '0)))
        else $error("enable word read back wrong");

    read_upper_a: assert property (
        (setup && !pwrite && hit_prio)
        |=> ((prdata[31:16] == 16'h0000)
             && ((prdata[15:0] & ~PRIO_MASK[$past(widx)]) == 16'h0000)))
        else $error("unimplemented bit read back nonzero");

    pend_read_a: assert property (
        (setup && !pwrite && (paddr == ADDR_W'(OFF_PEND)))
        |=> ((prdata[NUM_SRC-1:0] == $past(pend)) && (prdata[31:NUM_SRC] == '0)))
        else $error("pending word read back wrong");

    status_read_a: assert property (
        (setup && !pwrite && (paddr == ADDR_W'(OFF_STATUS)))
        |=> ((prdata[STAT_VALID_BIT] == $past(irq_valid))
             && (prdata[STAT_SRC_LSB +: 5] == $past(irq_source))
             && (prdata[STAT_LVL_LSB +: 3] == $past(irq_level))))
        else $error("status word read back wrong");

    // ------------------------------------------------------------
    // Reset and layout checks
    // ------------------------------------------------------------
    reset_fields_a: assert property (
        $past(!nrst) |-> (lvls == {NUM_SRC{3'h4}}))
        else $error("a field did not reset to level four");

    reset_outputs_a: assert property (
        $past(!nrst) |-> (!irq_valid && !pready && (prdata == 32'h0) && (st_q.en == '0)))
        else $error("outputs not idle after reset");

    word0_map_a: assert property (
        (lvls[0] == st_q.prio[0][14:12]) && (lvls[1] == st_q.prio[0][10:8])
        && (lvls[2] == st_q.prio[0][6:4]) && (lvls[3] == st_q.prio[0][2:0]))
        else $error("priority word 0 layout broken");

    word1_map_a: assert property (
        (lvls[4] == st_q.prio[1][14:12]) && (lvls[5] == st_q.prio[1][10:8])
        && (lvls[6] == st_q.prio[1][6:4]))
        else $error("priority word 1 layout broken");

    word2_map_a: assert property (
        (lvls[9] == st_q.prio[2][10:8]) && (lvls[10] == st_q.prio[2][6:4])
        && (lvls[11] == st_q.prio[2][2:0]))
        else $error("priority word 2 layout broken");

    word3_map_a: assert property (
        (lvls[12] == st_q.prio[3][10:8]) && (lvls[13] == st_q.prio[3][6:4])
        && (lvls[14] == st_q.prio[3][2:0]) && (st_q.prio[3][15:11] == 5'h00))
        else $error("priority word 3 layout broken");

    word4_low_a: assert property (
        (lvls[16] == st_q.prio[4][6:4]) && (lvls[17] == st_q.prio[4][2:0]))
        else $error("priority word 4 low fields broken");

    // ------------------------------------------------------------
    // Presentation checks
    // ------------------------------------------------------------
    idle_outputs_a: assert property (
        !irq_valid |-> ((irq_level == 3'h0) && (irq_source == 5'h00)))
        else $error("idle output carries a source or level");

    pend_shown_a: assert property (
        (pend != '0) |=> irq_valid)
        else $error("pending request not presented");

    source_range_a: assert property (
        irq_valid |-> (irq_source < 5'(NUM_SRC)))
        else $error("presented source number out of range");

    // Checked source by source: a moving index under $past reads the wrong field
    for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
        shown_pending_a: assert property (
            (irq_valid && (irq_source == 5'(g)))
            |-> ($past(pend[g]) && (irq_level == $past(lvls[g]))))
            else $error("presented source was not pending at its level");

        none_higher_a: assert property (
            $past(pend[g]) |-> (irq_valid && (irq_level >= $past(lvls[g]))))
            else $error("a higher pending source was passed over");

        tie_lowest_a: assert property (
            ($past(pend[g]) && (irq_level == $past(lvls[g]))) |-> (irq_source <= 5'(g)))
            else $error("tie not resolved to the lowest source");
    end

endmodule // ipr_ctrl

// ===== bench/ipr_src_model.sv
// Peripheral request sources facing the priority block
`timescale 1ns/10ps
module ipr_src_model
    import ipr_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic [NUM_SRC-1:0] req_set,
    output logic      [NUM_SRC-1:0] irq_req
);
    // Requests are levels held until the source clears them
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq_req <= '0;
        end else begin
            irq_req <= req_set;
        end
    end
endmodule // ipr_src_model

// ===== bench/tb_interrupt_priority_regs_0_to_4.sv
// Self-checking bench for the interrupt priority words
`timescale 1ns/10ps
module tb_interrupt_priority_regs_0_to_4
    import ipr_pkg::*;
;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, irq_valid, rd_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0] irq_source;
    logic [2:0] irq_level;
    logic [NUM_SRC-1:0] irq_req, req_set;
    int errors = 0, n_checks = 0, cyc = 0;
    // Field position of each source, in source order
    int lsb_tab [18] = '{12,8,4,0, 12,8,4,0, 12,8,4,0, 8,4,0, 12,4,0};
    ipr_ctrl u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .irq_req(irq_req), .irq_valid(irq_valid),
        .irq_source(irq_source), .irq_level(irq_level));
    ipr_src_model u_src (.clk(clk), .nrst(nrst), .req_set(req_set), .irq_req(irq_req));
    // ------------------------------------------------------------
    // Support tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        rd_err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // Arbitration lands one edge after the write completes
    task automatic chk_irq(input logic v, input logic [4:0] s, input logic [2:0] l);
        repeat (3) @(posedge clk);
        chk("presented", {23'h0, v, s, l}, {23'h0, irq_valid, irq_source, irq_level});
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        logic [15:0] rst_v [5] = '{16'h4444, 16'h4444, 16'h4444, 16'h0444, 16'h4044};
        logic [15:0] msk_v [5] = '{16'h7777, 16'h7777, 16'h7777, 16'h0777, 16'h7077};
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk("reset word", {16'h0, rst_v[i]}, rd);
            apb(1'b1, 8'(4 * i), 32'hFFFFFFFF);
            apb(1'b0, 8'(4 * i), 32'h0);
            chk("masked word", {16'h0, msk_v[i]}, rd);
        end
        apb(1'b1, 8'h20, 32'hFFFFFFFF);
        chk("unmapped err", 32'h1, {31'h0, rd_err});
        apb(1'b0, 8'h06, 32'h0);
        chk("unaligned err", 32'h1, {31'h0, rd_err});
        apb(1'b1, OFF_PEND, 32'hFFFFFFFF);
        chk("status write err", 32'h0, {31'h0, rd_err});
        $display("register test done");
    endtask
    task automatic t_map;
        int w;
        for (int i = 0; i < 5; i++) apb(1'b1, 8'(4 * i), 32'h0);
        apb(1'b1, OFF_ENABLE, 32'h0003FFFF);
        req_set <= '1;
        for (int s = 0; s < 18; s++) begin
            w = (s < 12) ? s / 4 : (s < 15) ? 3 : 4;
            apb(1'b1, 8'(4 * w), 32'(s % 7 + 1) << lsb_tab[s]);
            chk_irq(1'b1, 5'(s), 3'(s % 7 + 1));
            apb(1'b1, 8'(4 * w), 32'h0);
        end
        $display("field map test done");
    endtask
    task automatic t_arb;
        apb(1'b1, OFF_PRIO0, 32'h00000123);
        chk_irq(1'b1, 5'd3, 3'd3);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("status word", (32'h1 << STAT_VALID_BIT) | (32'h3 << STAT_SRC_LSB)
            | (32'h3 << STAT_LVL_LSB), rd);
        apb(1'b0, OFF_PEND, 32'h0);
        chk("pending word", 32'h0000000E, rd);
        apb(1'b1, OFF_ENABLE, 32'h0003FFF7);
        chk_irq(1'b1, 5'd2, 3'd2);
        apb(1'b0, OFF_ENABLE, 32'h0);
        chk("enable word", 32'h0003FFF7, rd);
        apb(1'b1, OFF_ENABLE, 32'h0003FFFF);
        apb(1'b1, OFF_PRIO0, 32'h00000222);
        chk_irq(1'b1, 5'd1, 3'd2);
        apb(1'b1, OFF_PRIO0, 32'h00007777);
        chk_irq(1'b1, 5'd0, 3'd7);
        apb(1'b1, OFF_PRIO0, 32'h0);
        chk_irq(1'b0, 5'd0, 3'd0);
        $display("arbitration test done");
    endtask
    // ------------------------------------------------------------
    // Clock, timeout and main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Whole run needs well under two thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            complete_run();
        end
    end
    initial begin
        nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; req_set = '0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_map();
        t_arb();
        complete_run();
    end
endmodule // tb_interrupt_priority_regs_0_to_4
